/* hw/adcro_pkg.sv */
package adcro_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_CH  = 8;                  // converter channels
   localparam int WORD_W  = 24;                 // bits per channel word
   localparam int FRAME_W = NUM_CH * WORD_W;    // own bits per frame
   localparam int CNT_W   = 9;                  // serial bit index width

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam logic [8:0] CONV_CYCLES     = 9'h100; // clk per conversion, spi
   localparam logic [8:0] DATA_READY_N_LEAD       = 9'h004; // no-readback pulse lead
   localparam logic [7:0] SYNC_SETTLE_SPI = 8'h80;  // 128 conversions
   localparam logic [7:0] SYNC_SETTLE_FS  = 8'h7f;  // 127 conversions
   localparam logic [7:0] PWUP_SETTLE_SPI = 8'h82;  // 130 conversions
   localparam logic [7:0] PWUP_SETTLE_FS  = 8'h81;  // 129 conversions
   localparam logic [1:0] CHANNEL_POWERDOWN_N_MIN_CLK    = 2'h2;   // low clk cycles to power down

   // ----------------------------------------------------------------
   // readout formats and channel states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ADCRO_SPI_DYN  = 3'b000,
      ADCRO_SPI_FIX  = 3'b001,
      ADCRO_SPI_DISC = 3'b010,
      ADCRO_FS_DYN   = 3'b011,
      ADCRO_FS_FIX   = 3'b100,
      ADCRO_FS_DISC  = 3'b101,
      ADCRO_MOD      = 3'b110,
      ADCRO_RSVD     = 3'b111
   } adcro_fmt_t;

   typedef enum logic [1:0] {
      ADCRO_CH_OFF    = 2'b00,
      ADCRO_CH_SETTLE = 2'b01,
      ADCRO_CH_ON     = 2'b10
   } adcro_ch_st_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef logic [NUM_CH-1:0][WORD_W-1:0] adcro_words_t; // [0] is channel 1

   typedef struct packed {
      adcro_ch_st_t st;       // power state
      logic [1:0]   pd_cnt;   // low cycles seen on powerdown pin
      logic [7:0]   settle;   // conversions since power-up
   } adcro_ch_t;

   typedef struct packed {
      logic                     rst_meta;
      logic                     rst_sync;
      logic [NUM_CH-1:0]        pd_meta;
      logic [NUM_CH-1:0]        pd_sync;
      logic                     fs_meta;
      logic                     fs_sync;
      logic                     fs_prev;
      logic [2:0]               fmt_meta;
      logic [2:0]               fmt_sync;
      logic                     tg_meta;
      logic                     tg_sync;
      logic                     tg_prev;
      adcro_fmt_t               fmt;
      logic [8:0]               conv_cnt;
      logic [7:0]               settle;
      adcro_ch_t [NUM_CH-1:0]   ch;
      logic [FRAME_W-1:0]       frame;
      logic [CNT_W-1:0]         nbits;
      logic                     data_ready_n_n;
      logic                     link_clr;
      logic                     bias_en;
      logic                     mod_clk;
      logic [NUM_CH-1:0]        mod_q;
      logic                     sclk_oe;
   } adcro_core_t;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;     // falling serial clock edges since load
      logic             chain_q; // last chained bit taken in
   } adcro_link_t;

endpackage

/* hw/adcro_top.sv */
// Operation
// - restart low halts conversion, clears filter counters
// - spi: ready flag high during restart, settling
// - sync settle: spi 129 max, fs 127-128
// - all channels down: bias off, outputs driven
// - power-up data: spi 129-130, fs 128-129
// - power changes leave running channels undisturbed
// - powered-up channels align to running conversions
// - tdm fixed zeroes slot, dynamic packs higher
// - discrete: powered-down channel output reads zero
// - dynamic tdm adds channel once data ready
// - three format pins select readout mode
// - spi read-only, ready flag falls, msb first
// - ready low on data, high first falling edge
// - no readback: ready pulses high before next
// - new data loaded at ready fall, overwrites
// - msb valid at ready low, next per fall
// - chain bits sampled on falls, follow own data
// - modulator mode: clock out, per-channel bitstreams
// - frame-sync: msb first from frame sync rise
// - tdm order channel 1 upward, then chain
`timescale 1ns/10ps
`default_nettype none

module adcro_top (
   input  wire logic                   clk,                  // master clock
   input  wire logic                   rstn,                 // async reset, low
   input  wire logic                   sclk_in,              // serial clock from host
   input  wire logic                   conversion_restart_n, // restart pin, low halts
   input  wire logic [7:0]             channel_powerdown_n,  // per-channel power pins
   input  wire logic [2:0]             output_format_select, // readout format pins
   input  wire logic                   frame_sync_in,        // frame clock from host
   input  wire logic                   chain_data_in,        // daisy-chain input
   input  wire adcro_pkg::adcro_words_t conv_words,          // filter results, clk domain
   input  wire logic [7:0]             mod_bits,             // modulator bitstreams
   output logic                        data_ready_n,         // ready flag, spi
   output logic [7:0]                  serial_data_out,      // data pins, [0] is tdm pin
   output logic                        sclk_out,             // modulator clock out
   output logic                        sclk_oe,              // drive enable of sclk pin
   output logic                        bias_enable           // low in micro-power state
);
   import adcro_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   adcro_core_t c;          // clk domain state
   adcro_core_t next_c;     // its next value
   adcro_link_t l;          // serial clock domain state
   adcro_link_t next_l;     // its next value
   logic        shift_tgl;  // flips on each falling serial edge
   logic        link_rst;   // clears the bit index at a load

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // spi formats are the three lowest codes
   function automatic logic is_spi(input adcro_fmt_t f);
      is_spi = (f == ADCRO_SPI_DYN) || (f == ADCRO_SPI_FIX) || (f == ADCRO_SPI_DISC);
   endfunction

   // frame-sync formats
   function automatic logic is_fs(input adcro_fmt_t f);
      is_fs = (f == ADCRO_FS_DYN) || (f == ADCRO_FS_FIX) || (f == ADCRO_FS_DISC);
   endfunction

   // discrete output formats
   function automatic logic is_disc(input adcro_fmt_t f);
      is_disc = (f == ADCRO_SPI_DISC) || (f == ADCRO_FS_DISC);
   endfunction

   // ----------------------------------------------------------------
   // clk domain next state
   // ----------------------------------------------------------------
   // one process covers syncing, conversion pacing, channel power and loads
   // every control pin comes from outside the clk domain, so each passes two flops
   // before any decision reads it; the format pins are treated the same way
   // even though a host usually ties them, since a change while running
   // must never reach the decoder half-settled
   always_comb begin
      logic                     spi;
      logic                     fs;
      logic                     tick;
      logic                     shift_ev;
      logic                     all_off;
      logic                     load;
      logic                     restart;
      logic [7:0]               sync_tgt;
      logic [7:0]               pwup_tgt;
      logic [FRAME_W-1:0]       fr;
      logic [3:0]               slot;
      spi      = is_spi(c.fmt);
      fs       = is_fs(c.fmt);
      tick     = 1'b0;
      shift_ev = 1'b0;
      all_off  = 1'b1;
      load     = 1'b0;
      restart  = 1'b0;
      sync_tgt = spi ? SYNC_SETTLE_SPI : SYNC_SETTLE_FS;
      pwup_tgt = spi ? PWUP_SETTLE_SPI : PWUP_SETTLE_FS;
      fr       = '0;
      slot     = 4'h0;
      next_c   = c;

      // two-stage synchronisers for the restart, power, frame sync and format pins and the shift toggle
      next_c.rst_meta = conversion_restart_n;
      next_c.rst_sync = c.rst_meta;
      next_c.pd_meta  = channel_powerdown_n;
      next_c.pd_sync  = c.pd_meta;
      next_c.fs_meta  = frame_sync_in;
      next_c.fs_sync  = c.fs_meta;
      next_c.fs_prev  = c.fs_sync;
      next_c.fmt_meta = output_format_select;
      next_c.fmt_sync = c.fmt_meta;
      next_c.tg_meta  = shift_tgl;
      next_c.tg_sync  = c.tg_meta;
      next_c.tg_prev  = c.tg_sync;
      next_c.fmt      = adcro_fmt_t'(c.fmt_sync);
      shift_ev        = c.tg_sync ^ c.tg_prev;

      // conversion pacing: own counter in spi, frame sync rise in frame-sync formats, none otherwise
      if (spi) begin
         tick = (c.conv_cnt == CONV_CYCLES - 9'h001);
      end else if (fs) begin
         tick = c.fs_sync & ~c.fs_prev;
      end
      next_c.conv_cnt = (tick || !spi) ? 9'h000 : c.conv_cnt + 9'h001;

      // the format register only follows the synced pins, so a change of
      // format shows here as a mismatch for one cycle and then acts like a
      // one-cycle restart pulse
      // a restart or a format change stops conversion and resets the filter
      restart = !c.rst_sync || (c.fmt != adcro_fmt_t'(c.fmt_sync));

      // per-channel power control: drop-out counts clk, settling counts the shared conversion tick
      // a channel drops out only after its pin reads low on two synced
      // clocks; a one-clock glitch merely bumps the counter, which clears
      // again as soon as the pin reads high
      // a returning channel counts conversion ticks rather than clk, so its
      // settling scales with the frame rate in either protocol
      for (int k = 0; k < NUM_CH; k++) begin
         if (!c.pd_sync[k]) begin
            if (c.ch[k].pd_cnt != CHANNEL_POWERDOWN_N_MIN_CLK) begin
               next_c.ch[k].pd_cnt = c.ch[k].pd_cnt + 2'h1;
            end
            if (c.ch[k].pd_cnt + 2'h1 >= CHANNEL_POWERDOWN_N_MIN_CLK) begin
               next_c.ch[k].st = ADCRO_CH_OFF;
            end
         end else begin
            next_c.ch[k].pd_cnt = 2'h0;
            case (c.ch[k].st)
               ADCRO_CH_OFF: begin
                  next_c.ch[k].st     = ADCRO_CH_SETTLE;
                  next_c.ch[k].settle = 8'h00;
               end
               ADCRO_CH_SETTLE: begin
                  // counts the common tick, so it joins in step
                  if (restart) begin
                     next_c.ch[k].settle = 8'h00;
                  end else if (tick) begin
                     next_c.ch[k].settle = c.ch[k].settle + 8'h01;
                     if (c.ch[k].settle + 8'h01 >= pwup_tgt) begin
                        next_c.ch[k].st = ADCRO_CH_ON;
                     end
                  end
               end
               ADCRO_CH_ON: begin
                  next_c.ch[k].st = ADCRO_CH_ON;
               end
               default: begin
                  next_c.ch[k].st = ADCRO_CH_OFF;
               end
            endcase
         end
         if (c.ch[k].st != ADCRO_CH_OFF) begin
            all_off = 1'b0;
         end
      end

      // micro-power once every channel is down; pins stay driven
      next_c.bias_en = !all_off;

      // global filter settling after restart
      // while this counter runs no frame is loaded, so the ready flag
      // cannot fall early and no stale frame reaches the pins
      if (restart) begin
         next_c.conv_cnt = 9'h000;
         next_c.settle   = 8'h00;
         next_c.frame    = '0;
         next_c.nbits    = '0;
      end else if (tick) begin
         if (c.settle != sync_tgt) begin
            next_c.settle = c.settle + 8'h01;
         end else if (!all_off && (spi || fs)) begin
            load = 1'b1;
         end
      end

      // frame build from the next channel states, channel 1 at the top
      // using the next states lets a channel that turns on at this tick join
      // the very frame loaded with it, and one that drops out leave at once;
      // running channels keep their order and their words either way
      if (load) begin
         for (int k = 0; k < NUM_CH; k++) begin
            if (next_c.ch[k].st == ADCRO_CH_ON) begin
               // dynamic packs ready channels, fixed keeps slot k
               if (c.fmt == ADCRO_SPI_DYN || c.fmt == ADCRO_FS_DYN) begin
                  fr[FRAME_W-1-WORD_W*int'(slot) -: WORD_W] = conv_words[k];
               end else begin
                  fr[FRAME_W-1-WORD_W*k -: WORD_W] = conv_words[k];
               end
               slot = slot + 4'h1;
            end
         end
         next_c.frame = fr;
         if (c.fmt == ADCRO_SPI_DYN || c.fmt == ADCRO_FS_DYN) begin
            next_c.nbits = CNT_W'(WORD_W * int'(slot));
         end else begin
            next_c.nbits = CNT_W'(FRAME_W);
         end
      end
      next_c.link_clr = load;

      // ready flag: spi only, high whenever no fresh data stands
      // the falling serial edge arrives through the toggle synchroniser, so
      // the rise lags it by two to three clk; a host faster than clk can
      // make two toggles cancel, leaving the flag low until the pulse
      if (!spi || restart || all_off) begin
         next_c.data_ready_n_n = 1'b1;
      end else if (load) begin
         next_c.data_ready_n_n = 1'b0;
      end else if (shift_ev) begin
         next_c.data_ready_n_n = 1'b1;
      end else if (c.conv_cnt == CONV_CYCLES - 9'h001 - DATA_READY_N_LEAD) begin
         next_c.data_ready_n_n = 1'b1;
      end

      // modulator output: clock driven out at half clk, bits registered
      // the bits are retimed by one flop only and change on every clk,
      // so the host must take them on the pin clock it is given
      next_c.sclk_oe = (c.fmt == ADCRO_MOD);
      next_c.mod_clk = (c.fmt == ADCRO_MOD) ? ~c.mod_clk : 1'b0;
      next_c.mod_q   = (c.fmt == ADCRO_MOD) ? mod_bits : '0;
   end

   // clk domain register; the ready flag idles high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         c         <= '0;
         c.data_ready_n_n  <= 1'b1;
         // channels leave reset running and the power pins read as up, so
         // the settle that follows reset covers every channel at once
         c.pd_meta <= '1;
         c.pd_sync <= '1;
         for (int k = 0; k < NUM_CH; k++) begin
            c.ch[k].st <= ADCRO_CH_ON;
         end
      end else begin
         c <= next_c;
      end
   end

   // ----------------------------------------------------------------
   // serial clock domain
   // ----------------------------------------------------------------
   // the bit index restarts at each load; loads fall while the host is idle
   // the clear is asynchronous to sclk_in; it comes from a clk flop and
   // holds a full clk, enough while the host keeps its clock idle across a
   // load, as it must
   assign link_rst = !rstn || c.link_clr;

   // index and chain capture advance on the falling edge
   always_comb begin
      next_l = l;
      if (l.cnt != {CNT_W{1'b1}}) begin
         next_l.cnt = l.cnt + 9'h001;
      end
      next_l.chain_q = chain_data_in;
   end

   // index register
   always_ff @(negedge sclk_in or posedge link_rst) begin
      if (link_rst) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // event toggle for the ready flag; only master reset clears it
   always_ff @(negedge sclk_in or negedge rstn) begin
      if (!rstn) begin
         shift_tgl <= 1'b0;
      end else begin
         shift_tgl <= ~shift_tgl;
      end
   end

   // ----------------------------------------------------------------
   // output pins
   // ----------------------------------------------------------------
   // the data pins select from the held frame by the falling-edge index;
   // a register here would lose the msb that must stand before any edge
   // the mux reads a clk-domain frame with an sclk-domain index; this holds
   // only because the frame stands still while the index moves, and the
   // index is cleared while the frame changes
   always_comb begin
      serial_data_out = '0;
      if (c.sclk_oe) begin
         // follows the registered enable, so clock and bits switch together
         serial_data_out = c.mod_q;
      end else if (c.bias_en && c.rst_sync) begin
         if (is_disc(c.fmt)) begin
            // each pin shifts its own word, zero after the 24th edge
            for (int k = 0; k < NUM_CH; k++) begin
               if (int'(l.cnt) < WORD_W) begin
                  serial_data_out[k] = c.frame[FRAME_W-1-WORD_W*k-int'(l.cnt)];
               end
            end
         end else if (is_spi(c.fmt) || is_fs(c.fmt)) begin
            // one pin, channel 1 first, then the chained stream
            if (l.cnt < c.nbits) begin
               serial_data_out[0] = c.frame[FRAME_W-1-int'(l.cnt)];
            end else begin
               serial_data_out[0] = l.chain_q;
            end
         end
      end
   end

   assign data_ready_n = c.data_ready_n_n;
   assign sclk_out     = c.mod_clk;
   assign sclk_oe      = c.sclk_oe;
   assign bias_enable  = c.bias_en;

endmodule

`default_nettype wire

/* tb/adcro_props_properties.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// port checker, master clock domain
// ----
module adcro_props (
   input wire logic       clk,                  // master clock
   input wire logic       rstn,                 // async reset, low
   input wire logic       conversion_restart_n, // restart pin
   input wire logic [7:0] channel_powerdown_n,  // power pins
   input wire logic [2:0] output_format_select, // format pins
   input wire logic [7:0] mod_bits,             // modulator bits in
   input wire logic       data_ready_n,         // ready flag
   input wire logic [7:0] serial_data_out,      // data pins
   input wire logic       sclk_out,             // modulator clock
   input wire logic       sclk_oe,              // sclk drive enable
   input wire logic       bias_enable           // bias on
);
   logic       dr_q;       // ready flag one clk ago
   logic [8:0] since_fall; // clk since last ready fall, saturates

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // saturating count, so a long settle never looks like a period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dr_q       <= 1'b1;
         since_fall <= 9'h1ff;
      end else begin
         dr_q       <= data_ready_n;
         since_fall <= (dr_q && !data_ready_n) ? 9'h000 :
                       (since_fall == 9'h1ff) ? since_fall : since_fall + 9'h001;
      end
   end

   chk_restart_ready: assert property (
      !conversion_restart_n [*5] |-> data_ready_n) else $error("ready low in restart");
   chk_restart_hold: assert property (
      !conversion_restart_n ##1 conversion_restart_n |-> data_ready_n [*8])
      else $error("ready fell before settling");
   chk_all_down: assert property (
      (channel_powerdown_n == 8'h00) [*8] |-> !bias_enable && data_ready_n)
      else $error("bias on with all channels down");
   chk_bias_on: assert property (
      (channel_powerdown_n == 8'hff) [*8] |-> bias_enable) else $error("bias off");
   chk_mod_enable: assert property (
      (output_format_select == 3'b110) [*6] |-> sclk_oe) else $error("sclk not driven");
   chk_mod_disable: assert property (
      (output_format_select != 3'b110) [*6] |-> !sclk_oe) else $error("sclk driven");
   chk_mod_toggle: assert property (
      sclk_oe && $past(sclk_oe) |-> sclk_out != $past(sclk_out))
      else $error("modulator clock stuck");
   chk_mod_data: assert property (
      sclk_oe && $past(sclk_oe) |-> serial_data_out == $past(mod_bits))
      else $error("modulator data wrong");
   chk_conv_period: assert property (
      dr_q && !data_ready_n && since_fall != 9'h1ff && output_format_select < 3'b011
      |-> since_fall == 9'h0ff) else $error("ready period not 256 clk");
   chk_ready_pulse: assert property (
      !dr_q && data_ready_n && since_fall >= 9'h0c8 && conversion_restart_n
      && (|channel_powerdown_n) && output_format_select == 3'b000
      |-> ##[1:8] !data_ready_n) else $error("no-readback pulse too long");
endmodule

bind adcro_top adcro_props u_props (
   .clk(clk), .rstn(rstn), .conversion_restart_n(conversion_restart_n),
   .channel_powerdown_n(channel_powerdown_n), .output_format_select(output_format_select),
   .mod_bits(mod_bits), .data_ready_n(data_ready_n), .serial_data_out(serial_data_out),
   .sclk_out(sclk_out), .sclk_oe(sclk_oe), .bias_enable(bias_enable)
);
`default_nettype wire

/* tb/adcro_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// host reading the tdm pin; its serial clock stands low between frames
module adcro_host_model (
   input  wire logic clk,          // master clock
   input  wire logic sdo,          // tdm data pin
   output logic      sclk_in,      // serial clock, 80 ns period
   output logic      chain_data_in // daisy-chain bits
);
   logic [255:0] cap;   // bits taken on rising edges, wraps on long reads
   int           falls; // falling edges given in this frame

   initial begin
      sclk_in       = 1'b0;
      chain_data_in = 1'b0;
   end

   // read n bits; caller keeps n short enough to end before the next load
   task automatic read(input int n);
      begin
         @(posedge clk);
         #7;
         falls         = 0;
         chain_data_in = 1'b0;
         for (int i = 0; i < n; i++) begin
            sclk_in = 1'b1;
            cap[i % 256] = sdo;
            #40 sclk_in = 1'b0;
            falls++;
            #1 chain_data_in = falls[1];
            #39;
         end
         chain_data_in = ~chain_data_in;
      end
   endtask
endmodule
`default_nettype wire

/* tb/adc_serial_readout_and_powerdown_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module adc_serial_readout_and_powerdown_tb_top;
   import adcro_pkg::*;

   logic         clk, rstn, conversion_restart_n, frame_sync_in, sclk_in, chain_data_in;
   logic         data_ready_n, sclk_out, sclk_oe, bias_enable;
   logic [7:0]   channel_powerdown_n, mod_bits, serial_data_out, mod_q;
   logic [2:0]   output_format_select;
   adcro_words_t conv_words;
   logic [255:0] exp_v;
   int           error_cnt = 0;
   int           total_checks = 0;
   int           tmo = 0;
   int           n;

   adcro_top dut (.clk(clk), .rstn(rstn), .sclk_in(sclk_in),
      .conversion_restart_n(conversion_restart_n), .channel_powerdown_n(channel_powerdown_n),
      .output_format_select(output_format_select), .frame_sync_in(frame_sync_in),
      .chain_data_in(chain_data_in), .conv_words(conv_words), .mod_bits(mod_bits),
      .data_ready_n(data_ready_n), .serial_data_out(serial_data_out),
      .sclk_out(sclk_out), .sclk_oe(sclk_oe), .bias_enable(bias_enable));

   adcro_host_model host (.clk(clk), .sdo(serial_data_out[0]), .sclk_in(sclk_in),
      .chain_data_in(chain_data_in));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // hang guard, well above the two settling waits
   always @(posedge clk) begin
      tmo <= tmo + 1;
      if (tmo == 80000) begin
         error_cnt++;
         complete_run;
      end
   end

   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // wait for a falling ready flag, bounded
   task automatic wait_fall(input int lim, output int c);
      logic p;
      begin
         p = data_ready_n;
         c = 0;
         forever begin
            @(posedge clk);
            #1 c++;
            if ((p === 1'b1 && data_ready_n === 1'b0) || c >= lim) break;
            p = data_ready_n;
         end
         if (c >= lim) chk(32'h0, 32'h1);
      end
   endtask

   // reference frame: ascending on channels, msb first, then chain bits
   function automatic logic [255:0] exp_frame(input logic [7:0] on);
      logic [255:0] v;
      int           p;
      begin
         v = '0;
         p = 0;
         for (int c = 0; c < 8; c++) if (on[c]) begin
            for (int b = 0; b < 24; b++) v[p+b] = conv_words[c][23-b];
            p += 24;
         end
         for (int i = p; i < 256; i++) v[i] = (((i - 1) >> 1) & 1) == 1;
         return v;
      end
   endfunction

   task automatic read_cmp(input int nb, input logic [7:0] on);
      exp_v = exp_frame(on);
      host.read(nb);
      for (int i = 0; i < nb; i += 8) chk(host.cap[i+:8], exp_v[i+:8]);
      @(posedge clk);
      for (int c = 0; c < 8; c++) conv_words[c] <= 24'($urandom);
   endtask

   initial begin
      void'($urandom(81));
      rstn = 1'b0;
      conversion_restart_n = 1'b1;
      channel_powerdown_n = 8'hff;
      output_format_select = 3'h0;
      frame_sync_in = 1'b0;
      mod_bits = 8'h00;
      for (int c = 0; c < 8; c++) conv_words[c] = 24'($urandom);
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      wait_fall(34000, n);
      chk(n <= 129 * 256 + 8, 1);
      read_cmp(144, 8'hff);
      $display("test settle done");
      @(posedge clk) channel_powerdown_n <= 8'hfa;
      wait_fall(300, n);
      wait_fall(300, n);
      read_cmp(152, 8'hfa);
      $display("test powerdown done");
      wait_fall(300, n);
      @(posedge clk) channel_powerdown_n <= 8'hfe;
      for (int k = 1; k <= 130; k++) begin
         wait_fall(300, n);
         if (k == 128) read_cmp(24, 8'hfa);
         if (k == 130) read_cmp(48, 8'hfe);
      end
      $display("test powerup done");
      @(posedge clk) conversion_restart_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(data_ready_n, 1);
      @(posedge clk) conversion_restart_n <= 1'b1;
      channel_powerdown_n <= 8'h00;
      repeat (8) @(posedge clk);
      #1 chk(bias_enable, 0);
      @(posedge clk) channel_powerdown_n <= 8'hff;
      repeat (8) @(posedge clk);
      #1 chk(bias_enable, 1);
      $display("test restart and micro-power done");
      for (int f = 0; f < 8; f++) begin
         @(posedge clk) output_format_select <= 3'(f);
         repeat (8) @(posedge clk);
         #1 chk(sclk_oe, f == 6);
      end
      @(posedge clk) output_format_select <= 3'h6;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         mod_q = mod_bits;
         mod_bits <= 8'($urandom);
         #1 chk(serial_data_out, mod_q);
      end
      $display("test formats done");
      // frame-sync host: frame clock at the conversion period, serial clock unbroken
      @(posedge clk) output_format_select <= 3'h3;
      fork
         host.read(620);
         for (int f = 0; f < 4; f++) begin
            @(posedge clk) frame_sync_in <= 1'b1;
            repeat (128) @(posedge clk);
            frame_sync_in <= 1'b0;
            repeat (127) @(posedge clk);
            #1 chk({data_ready_n, sclk_oe}, 2'b10);
         end
      join
      $display("test frame-sync done");
      complete_run;
   end
endmodule
`default_nettype wire
